//--- rtl/i2c_bus_master.sv
// master end of the two-wire link: start, stop, byte write and byte read
// on command, with the serial clock divided from mclk_i at three speeds
// assumes one command at a time; honours a slave holding scl low
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_master (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // bus
  i2c_bus_if.master bus,
  // command
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_i,
  input wire logic [7:0] wdata_i,
  input wire logic last_i,
  input wire logic [1:0] speed_i,
  output logic cmd_ready_o,
  // result
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic ack_o
);
  typedef struct packed {
    i2c_link_pkg::mst_state_e st;
    logic [9:0] tmr;
    logic [9:0] half;
    logic [7:0] sh;
    logic [3:0] bits;
    logic rd;
    logic last;
    logic scl_oe;
    logic sda_oe;
    logic ready;
    logic done;
    logic [7:0] rdata;
    logic ack;
  } mst_s;

  mst_s q, d;
  logic [1:0] filt;
  logic scl_f, sda_f, tick;

  function automatic logic [9:0] half_of(input logic [1:0] sp);
    case (sp)
      i2c_link_pkg::SPEED_FAST: half_of = 10'(i2c_link_pkg::HALF_FAST_CYC);
      i2c_link_pkg::SPEED_HS: half_of = 10'(i2c_link_pkg::HALF_HS_CYC);
      default: half_of = 10'(i2c_link_pkg::HALF_STD_CYC);
    endcase
  endfunction

  i2c_glitch_filter #(
    .W(2),
    .LEN(i2c_link_pkg::FILT_CYC)
  ) u_filt (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .raw_i({bus.sda, bus.scl}),
    .filt_o(filt)
  );

  assign scl_f = filt[0];
  assign sda_f = filt[1];
  assign tick = (q.tmr == 10'h000);

  always_comb begin
    d = q;
    d.done = 1'b0;
    // high phases start counting only once scl is really high, so stretching works
    if (!tick && (scl_f || (q.st != i2c_link_pkg::MST_S_HIGH &&
        q.st != i2c_link_pkg::MST_P_HIGH && q.st != i2c_link_pkg::MST_B_HIGH))) begin
      d.tmr = q.tmr - 10'h001;
    end
    case (q.st)
      i2c_link_pkg::MST_IDLE: begin
        if (cmd_valid_i && q.ready) begin
          d.ready = 1'b0;
          d.half = half_of(speed_i);
          d.tmr = half_of(speed_i);
          d.sh = wdata_i;
          d.bits = '0;
          d.rd = (cmd_i == i2c_link_pkg::CMD_READ);
          d.last = last_i;
          case (cmd_i)
            i2c_link_pkg::CMD_START: begin
              d.sda_oe = 1'b0;
              d.st = i2c_link_pkg::MST_S_REL;
            end
            i2c_link_pkg::CMD_STOP: begin
              d.sda_oe = 1'b1;
              d.st = i2c_link_pkg::MST_P_LOW;
            end
            i2c_link_pkg::CMD_WRITE: begin
              d.sda_oe = ~wdata_i[7];
              d.st = i2c_link_pkg::MST_B_LOW;
            end
            default: begin
              d.sda_oe = 1'b0;
              d.st = i2c_link_pkg::MST_B_LOW;
            end
          endcase
        end
      end
      i2c_link_pkg::MST_S_REL: begin
        if (tick) begin
          d.scl_oe = 1'b0;
          d.tmr = q.half;
          d.st = i2c_link_pkg::MST_S_HIGH;
        end
      end
      i2c_link_pkg::MST_S_HIGH: begin
        if (tick) begin
          d.sda_oe = 1'b1;
          d.tmr = q.half;
          d.st = i2c_link_pkg::MST_S_LOW;
        end
      end
      i2c_link_pkg::MST_S_LOW: begin
        if (tick) begin
          d.scl_oe = 1'b1;
          d.st = i2c_link_pkg::MST_IDLE;
          d.ready = 1'b1;
          d.done = 1'b1;
        end
      end
      i2c_link_pkg::MST_P_LOW: begin
        if (tick) begin
          d.scl_oe = 1'b0;
          d.tmr = q.half;
          d.st = i2c_link_pkg::MST_P_HIGH;
        end
      end
      i2c_link_pkg::MST_P_HIGH: begin
        if (tick) begin
          d.sda_oe = 1'b0;
          d.tmr = q.half;
          d.st = i2c_link_pkg::MST_P_FREE;
        end
      end
      i2c_link_pkg::MST_P_FREE: begin
        if (tick) begin
          d.st = i2c_link_pkg::MST_IDLE;
          d.ready = 1'b1;
          d.done = 1'b1;
        end
      end
      i2c_link_pkg::MST_B_LOW: begin
        if (tick) begin
          d.scl_oe = 1'b0;
          d.tmr = q.half;
          d.st = i2c_link_pkg::MST_B_HIGH;
        end
      end
      i2c_link_pkg::MST_B_HIGH: begin
        if (tick) begin
          d.scl_oe = 1'b1;
          d.tmr = q.half;
          if (q.bits == i2c_link_pkg::BITS_PER_WORD) begin
            d.ack = ~sda_f;
            d.rdata = q.sh;
            d.sda_oe = 1'b0;
            d.st = i2c_link_pkg::MST_IDLE;
            d.ready = 1'b1;
            d.done = 1'b1;
          end else begin
            d.sh = {q.sh[6:0], sda_f};
            d.bits = q.bits + 4'h1;
            d.st = i2c_link_pkg::MST_B_LOW;
            if (q.bits == 4'h7) begin
              d.sda_oe = q.rd & ~q.last;
            end else begin
              d.sda_oe = ~q.rd & ~q.sh[6];
            end
          end
        end
      end
      default: begin
        d.st = i2c_link_pkg::MST_IDLE;
        d.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{st: i2c_link_pkg::MST_IDLE, tmr: '0, half: '0, sh: '0, bits: '0,
             rd: 1'b0, last: 1'b0, scl_oe: 1'b0, sda_oe: 1'b0, ready: 1'b1,
             done: 1'b0, rdata: '0, ack: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign bus.scl_m_o = 1'b0;
  assign bus.sda_m_o = 1'b0;
  assign bus.scl_m_oe = q.scl_oe;
  assign bus.sda_m_oe = q.sda_oe;
  assign cmd_ready_o = q.ready;
  assign done_o = q.done;
  assign rdata_o = q.rdata;
  assign ack_o = q.ack;
endmodule
`default_nettype wire

//--- rtl/i2c_glitch_filter.sv
// two-flop synchroniser plus stability filter for a group of pin inputs
// assumes inputs come from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module i2c_glitch_filter #(
  parameter int W = 2,
  parameter int LEN = i2c_link_pkg::FILT_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // pins and filtered levels
  input wire logic [W-1:0] raw_i,
  output logic [W-1:0] filt_o
);
  localparam int CW = $clog2(LEN + 1);
  localparam logic [CW-1:0] LAST = CW'(LEN - 1);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] filt;
    logic [W-1:0][CW-1:0] cnt;
  } flt_s;

  flt_s q, d;

  always_comb begin
    d = q;
    d.s1 = raw_i;
    d.s2 = q.s1;
    for (int i = 0; i < W; i++) begin
      // only the second flop is looked at
      if (q.s2[i] == q.filt[i]) begin
        d.cnt[i] = '0;
      end else if (q.cnt[i] == LAST) begin
        d.filt[i] = q.s2[i];
        d.cnt[i] = '0;
      end else begin
        d.cnt[i] = q.cnt[i] + CW'(1);
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{s1: '1, s2: '1, filt: '1, cnt: '0};
    end else begin
      q <= d;
    end
  end

  assign filt_o = q.filt;
endmodule
`default_nettype wire

//--- rtl/i2c_touch_slave.sv
// slave end of the two-wire link: address match, byte receive with ack,
// byte transmit, high-speed entry by master code and clock stretching in high speed only
// assumes the bus wires arrive through i2c_bus_if; all logic on mclk_i
`timescale 1ns/1ps
`default_nettype none
module i2c_touch_slave (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // bus
  i2c_bus_if.device bus,
  // strap pin
  input wire logic address_select_pin_i,
  // received bytes
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  // bytes to send
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  // status
  output logic selected_o,
  output logic read_mode_o,
  output logic hs_mode_o
);
  typedef struct packed {
    i2c_link_pkg::dev_state_e st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic rw;
    logic hs;
    logic nack;
    logic sel;
    logic scl_p;
    logic sda_p;
    logic scl_oe;
    logic sda_oe;
    logic [7:0] rx_data;
    logic rx_valid;
    logic [7:0] tx_buf;
    logic tx_empty;
  } dev_s;

  dev_s q, d;
  logic [2:0] filt;
  logic scl_f, sda_f, pin_f;
  logic rise, fall, start, stop;

  // filter length is short enough for high-speed high phases
  i2c_glitch_filter #(
    .W(3),
    .LEN(i2c_link_pkg::FILT_CYC)
  ) u_filt (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .raw_i({address_select_pin_i, bus.sda, bus.scl}),
    .filt_o(filt)
  );

  assign scl_f = filt[0];
  assign sda_f = filt[1];
  assign pin_f = filt[2];

  always_comb begin
    d = q;
    d.rx_valid = 1'b0;
    d.scl_p = scl_f;
    d.sda_p = sda_f;
    rise = scl_f & ~q.scl_p;
    fall = ~scl_f & q.scl_p;
    start = scl_f & q.scl_p & q.sda_p & ~sda_f;
    stop = scl_f & q.scl_p & ~q.sda_p & sda_f;

    if (start) begin
      // a repeated start lands here too, keeping the speed mode
      d.st = i2c_link_pkg::DEV_ADDR;
      d.bits = '0;
      d.sel = 1'b0;
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
    end else if (stop) begin
      d.st = i2c_link_pkg::DEV_IDLE;
      d.hs = 1'b0;
      d.sel = 1'b0;
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
    end else begin
      case (q.st)
        i2c_link_pkg::DEV_ADDR: begin
          if (rise) begin
            d.sh = {q.sh[6:0], sda_f};
            d.bits = q.bits + 4'h1;
          end else if (fall && q.bits == i2c_link_pkg::BITS_PER_WORD) begin
            d.bits = '0;
            if (q.sh[7:3] == i2c_link_pkg::MCODE_HI) begin
              d.hs = 1'b1;
              d.st = i2c_link_pkg::DEV_IDLE;
            end else if (q.sh[7:1] == {i2c_link_pkg::ADDR_HI, pin_f}) begin
              d.sel = 1'b1;
              d.rw = q.sh[0];
              d.sda_oe = 1'b1;
              d.st = i2c_link_pkg::DEV_ADDR_ACK;
            end else begin
              d.st = i2c_link_pkg::DEV_IDLE;
            end
          end
        end
        i2c_link_pkg::DEV_ADDR_ACK: begin
          // ack held from the fall before the ninth pulse to the fall after it
          if (fall) begin
            d.sda_oe = 1'b0;
            d.st = q.rw ? i2c_link_pkg::DEV_TX_WAIT : i2c_link_pkg::DEV_RX;
          end
        end
        i2c_link_pkg::DEV_RX: begin
          if (rise) begin
            d.sh = {q.sh[6:0], sda_f};
            d.bits = q.bits + 4'h1;
          end else if (fall && q.bits == i2c_link_pkg::BITS_PER_WORD) begin
            d.bits = '0;
            d.rx_data = q.sh;
            d.rx_valid = 1'b1;
            d.sda_oe = 1'b1;
            d.st = i2c_link_pkg::DEV_RX_ACK;
          end
        end
        i2c_link_pkg::DEV_RX_ACK: begin
          if (fall) begin
            d.sda_oe = 1'b0;
            d.st = i2c_link_pkg::DEV_RX;
          end
        end
        i2c_link_pkg::DEV_TX_WAIT: begin
          // below high speed the clock cannot be held, so a stale byte goes out
          if (!q.tx_empty || !q.hs) begin
            d.sh = q.tx_buf;
            d.tx_empty = 1'b1;
            d.sda_oe = ~q.tx_buf[7];
            d.bits = '0;
            d.st = i2c_link_pkg::DEV_TX;
          end else begin
            d.scl_oe = 1'b1;
          end
        end
        i2c_link_pkg::DEV_TX: begin
          // clock let go one cycle after data, giving setup time
          d.scl_oe = 1'b0;
          if (rise) begin
            d.bits = q.bits + 4'h1;
          end else if (fall) begin
            if (q.bits == i2c_link_pkg::BITS_PER_WORD) begin
              d.sda_oe = 1'b0;
              d.bits = '0;
              d.st = i2c_link_pkg::DEV_TX_ACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
            end
          end
        end
        i2c_link_pkg::DEV_TX_ACK: begin
          if (rise) begin
            d.nack = sda_f;
          end else if (fall) begin
            // no ack: leave the line high so the master can stop
            d.st = q.nack ? i2c_link_pkg::DEV_IDLE : i2c_link_pkg::DEV_TX_WAIT;
          end
        end
        i2c_link_pkg::DEV_IDLE: begin
          d.sda_oe = 1'b0;
          d.scl_oe = 1'b0;
        end
        default: begin
          d.st = i2c_link_pkg::DEV_IDLE;
        end
      endcase
    end

    if (tx_valid_i && q.tx_empty) begin
      d.tx_buf = tx_data_i;
      d.tx_empty = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{st: i2c_link_pkg::DEV_IDLE, bits: '0, sh: '0, rw: 1'b0, hs: 1'b0,
             nack: 1'b0, sel: 1'b0, scl_p: 1'b1, sda_p: 1'b1, scl_oe: 1'b0,
             sda_oe: 1'b0, rx_data: '0, rx_valid: 1'b0, tx_buf: '0, tx_empty: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign bus.scl_s_o = 1'b0;
  assign bus.sda_s_o = 1'b0;
  assign bus.scl_s_oe = q.scl_oe;
  assign bus.sda_s_oe = q.sda_oe;
  assign rx_data_o = q.rx_data;
  assign rx_valid_o = q.rx_valid;
  assign tx_ready_o = q.tx_empty;
  assign selected_o = q.sel;
  assign read_mode_o = q.rw;
  assign hs_mode_o = q.hs;
endmodule
`default_nettype wire

//--- shared/i2c_bus_if.sv
// the two open-drain wires shared by master and slave
// each party gives out value and enable; a driven pin pulls low, else it floats high
`timescale 1ns/1ps
`default_nettype none
interface i2c_bus_if;
  logic scl;
  logic sda;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic scl_s_o;
  logic scl_s_oe;
  logic sda_s_o;
  logic sda_s_oe;

  // wired-and with pull-ups
  assign scl = ~((scl_m_oe & ~scl_m_o) | (scl_s_oe & ~scl_s_o));
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

  modport master (
    input scl, sda,
    output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe
  );
  modport device (
    input scl, sda,
    output scl_s_o, scl_s_oe, sda_s_o, sda_s_oe
  );
endinterface
`default_nettype wire

//--- shared/i2c_link_pkg.sv
// shared constants and state types for both ends of the two-wire link
// assumes a 100 MHz system clock on both ends
package i2c_link_pkg;

  localparam int CLK_NS = 10;

  // fixed upper address bits; the lsb comes from the address select pin
  localparam logic [5:0] ADDR_HI = 6'h24;
  // high-speed master code pattern in the top five bits
  localparam logic [4:0] MCODE_HI = 5'h01;

  // glitch filter: a level must hold this long before it is believed
  localparam int FILT_NS = 30;
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;

  // half periods of the generated serial clock, as least times
  localparam int HALF_STD_NS = 5000;
  localparam int HALF_FAST_NS = 1250;
  localparam int HALF_HS_NS = 147;
  localparam int HALF_STD_CYC = (HALF_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALF_FAST_CYC = (HALF_FAST_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALF_HS_CYC = (HALF_HS_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [1:0] SPEED_STD = 2'h0;
  localparam logic [1:0] SPEED_FAST = 2'h1;
  localparam logic [1:0] SPEED_HS = 2'h2;

  localparam logic [1:0] CMD_START = 2'h0;
  localparam logic [1:0] CMD_STOP = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [1:0] CMD_READ = 2'h3;

  localparam logic [3:0] BITS_PER_WORD = 4'h8;

  typedef enum logic [2:0] {
    DEV_IDLE = 3'b000,
    DEV_ADDR = 3'b001,
    DEV_ADDR_ACK = 3'b010,
    DEV_RX = 3'b011,
    DEV_RX_ACK = 3'b100,
    DEV_TX_WAIT = 3'b101,
    DEV_TX = 3'b110,
    DEV_TX_ACK = 3'b111
  } dev_state_e;

  typedef enum logic [3:0] {
    MST_IDLE = 4'b0000,
    MST_S_REL = 4'b0001,
    MST_S_HIGH = 4'b0010,
    MST_S_LOW = 4'b0011,
    MST_P_LOW = 4'b0100,
    MST_P_HIGH = 4'b0101,
    MST_P_FREE = 4'b0110,
    MST_B_LOW = 4'b0111,
    MST_B_HIGH = 4'b1000,
    MST_IGNORE = 4'b1001
  } mst_state_e;

endpackage

//--- verification/tb_touch_adc_i2c_slave_port.sv
// self-checking bench: bus master end drives the touch slave end over the bus
// assumes the shared package and interface are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_touch_adc_i2c_slave_port;
  logic mclk_i;
  logic rst_i;
  logic pin;
  logic [7:0] rx_data;
  logic rx_valid;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic selected;
  logic read_mode;
  logic hs_mode;
  logic cmd_valid;
  logic [1:0] cmd;
  logic [7:0] wdata;
  logic last;
  logic [1:0] spd;
  logic cmd_ready;
  logic done;
  logic [7:0] rdata;
  logic ack;
  logic [7:0] rx_got;
  logic [7:0] d0;
  logic [7:0] d1;
  int n_mismatch;
  int check_count;
  int seed;

  i2c_bus_if link ();
  i2c_touch_slave i2c_touch_slave_inst (.mclk_i(mclk_i), .rst_i(rst_i), .bus(link),
    .address_select_pin_i(pin), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
    .selected_o(selected), .read_mode_o(read_mode), .hs_mode_o(hs_mode));
  i2c_bus_master i2c_bus_master_inst (.mclk_i(mclk_i), .rst_i(rst_i), .bus(link),
    .cmd_valid_i(cmd_valid), .cmd_i(cmd), .wdata_i(wdata), .last_i(last), .speed_i(spd),
    .cmd_ready_o(cmd_ready), .done_o(done), .rdata_o(rdata), .ack_o(ack));
  touch_link_properties touch_link_properties_inst (.mclk_i(mclk_i), .rst_i(rst_i),
    .address_select_pin(pin),
    .scl(link.scl), .sda(link.sda), .scl_s_oe(link.scl_s_oe), .sda_s_oe(link.sda_s_oe));

  initial begin
    mclk_i = 1'h0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    if (rx_valid === 1'h1) rx_got <= rx_data;
  end

  function automatic logic [7:0] addr_of(input logic rw);
    return {i2c_link_pkg::ADDR_HI, pin, rw};
  endfunction

  task automatic wrap_up();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      n_mismatch++;
    end
  endtask

  // which: 0 done, 1 command ready, 2 tx buffer free
  task automatic wait_hi(input int which, input int lim);
    int n;
    logic v;
    n = 0;
    while (n < lim) begin
      v = (which == 0) ? done : ((which == 1) ? cmd_ready : tx_ready);
      if (v === 1'h1) break;
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (n >= lim) begin
      $display("[FAIL] %0t wait ran out", $time);
      n_mismatch++;
      wrap_up();
    end
  endtask

  task automatic go(input logic [1:0] c, input logic [7:0] dat, input logic lst);
    wait_hi(1, 100);
    cmd_valid = 1'h1;
    cmd = c;
    wdata = dat;
    last = lst;
    @(posedge mclk_i);
    #1;
    cmd_valid = 1'h0;
    wait_hi(0, 30000);
  endtask

  task automatic load(input logic [7:0] dat);
    wait_hi(2, 100);
    tx_valid = 1'h1;
    tx_data = dat;
    @(posedge mclk_i);
    #1;
    tx_valid = 1'h0;
  endtask

  initial begin
    n_mismatch = 0;
    check_count = 0;
    rst_i = 1'h1;
    cmd_valid = 1'h0;
    cmd = 2'h0;
    wdata = 8'h00;
    last = 1'h0;
    spd = i2c_link_pkg::SPEED_STD;
    tx_valid = 1'h0;
    tx_data = 8'h00;
    seed = $urandom(32'h0000_fe76);
    pin = 1'($urandom);
    repeat (3) @(posedge mclk_i);
    #1;
    rst_i = 1'h0;
    repeat (6) @(posedge mclk_i);
    #1;
    // standard speed address phase only: a byte here costs ~9000 cycles
    go(i2c_link_pkg::CMD_START, 8'h00, 1'h0);
    go(i2c_link_pkg::CMD_WRITE, addr_of(1'h0), 1'h0);
    chk(ack, 8'h01, "std address ack");
    chk(selected, 8'h01, "selected after match");
    chk(read_mode, 8'h00, "write direction");
    go(i2c_link_pkg::CMD_STOP, 8'h00, 1'h0);
    // fast burst including all-zero and all-one bytes
    spd = i2c_link_pkg::SPEED_FAST;
    go(i2c_link_pkg::CMD_START, 8'h00, 1'h0);
    go(i2c_link_pkg::CMD_WRITE, addr_of(1'h0), 1'h0);
    for (int i = 0; i < 5; i++) begin
      d0 = (i == 1) ? 8'h00 : ((i == 2) ? 8'hff : 8'($urandom));
      go(i2c_link_pkg::CMD_WRITE, d0, 1'h0);
      chk(ack, 8'h01, "write byte ack");
      chk(rx_got, d0, "received byte");
    end
    go(i2c_link_pkg::CMD_STOP, 8'h00, 1'h0);
    // address whose lsb disagrees with the strap pin
    go(i2c_link_pkg::CMD_START, 8'h00, 1'h0);
    go(i2c_link_pkg::CMD_WRITE, addr_of(1'h0) ^ 8'h02, 1'h0);
    chk(ack, 8'h00, "foreign lsb nack");
    chk(selected, 8'h00, "not selected");
    go(i2c_link_pkg::CMD_STOP, 8'h00, 1'h0);
    // fast read of two bytes, the last one nacked
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    load(d0);
    go(i2c_link_pkg::CMD_START, 8'h00, 1'h0);
    go(i2c_link_pkg::CMD_WRITE, addr_of(1'h1), 1'h0);
    chk(ack, 8'h01, "read address ack");
    chk(read_mode, 8'h01, "read direction");
    // below high speed the slave cannot stretch: the next byte must sit in the buffer
    // before the ack fall of the current one, or the stale byte goes out again
    load(d1);
    go(i2c_link_pkg::CMD_READ, 8'h00, 1'h0);
    chk(rdata, d0, "first read byte");
    go(i2c_link_pkg::CMD_READ, 8'h00, 1'h1);
    chk(rdata, d1, "last read byte");
    go(i2c_link_pkg::CMD_STOP, 8'h00, 1'h0);
    // high speed entry, then a stretched read and a chained write
    go(i2c_link_pkg::CMD_START, 8'h00, 1'h0);
    go(i2c_link_pkg::CMD_WRITE, {i2c_link_pkg::MCODE_HI, 3'($urandom)}, 1'h0);
    chk(ack, 8'h00, "master code nack");
    chk(hs_mode, 8'h01, "high speed entered");
    spd = i2c_link_pkg::SPEED_HS;
    go(i2c_link_pkg::CMD_START, 8'h00, 1'h0);
    go(i2c_link_pkg::CMD_WRITE, addr_of(1'h1), 1'h0);
    chk(ack, 8'h01, "hs address ack");
    d0 = 8'($urandom);
    // late load forces the slave to hold scl low meanwhile
    fork
      begin
        repeat (200) @(posedge mclk_i);
        #1;
        load(d0);
      end
      go(i2c_link_pkg::CMD_READ, 8'h00, 1'h1);
    join
    chk(rdata, d0, "stretched read byte");
    go(i2c_link_pkg::CMD_START, 8'h00, 1'h0);
    go(i2c_link_pkg::CMD_WRITE, addr_of(1'h0), 1'h0);
    chk(ack, 8'h01, "address after repeated start");
    chk(read_mode, 8'h00, "write after read");
    d1 = 8'($urandom);
    go(i2c_link_pkg::CMD_WRITE, d1, 1'h0);
    chk(rx_got, d1, "chained hs byte");
    chk(hs_mode, 8'h01, "hs kept over repeated start");
    go(i2c_link_pkg::CMD_STOP, 8'h00, 1'h0);
    repeat (10) @(posedge mclk_i);
    #1;
    chk(hs_mode, 8'h00, "hs left on stop");
    wrap_up();
  end
endmodule
`default_nettype wire

//--- verification/touch_link_properties.sv
// assertions on the two bus wires and on the slave's pull-down enables
// assumes it sits beside the bus interface in the bench top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module touch_link_properties (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // strap level that picks the address lsb
  input wire logic address_select_pin,
  // resolved wires and enables
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_s_oe,
  input wire logic sda_s_oe
);
  typedef struct packed {
    logic scl;
    logic sda;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic first;
    logic rd;
    logic wr;
    logic hs;
  } trk_s;
  trk_s trk_q;
  trk_s trk_d;
  logic rise;
  logic rise9;
  logic start_ev;
  logic stop_ev;

  assign rise = scl & ~trk_q.scl;
  assign rise9 = rise & (trk_q.cnt == 4'h8);
  assign start_ev = scl & trk_q.scl & trk_q.sda & ~sda;
  assign stop_ev = scl & trk_q.scl & ~trk_q.sda & sda;

  // raw-wire tracker of bit count, first byte and selected direction
  always_comb begin
    trk_d = trk_q;
    trk_d.scl = scl;
    trk_d.sda = sda;
    if (rise) begin
      if (trk_q.cnt == 4'h8) begin
        trk_d.cnt = 4'h0;
        if (trk_q.first) begin
          trk_d.first = 1'h0;
          trk_d.hs = trk_q.hs | (trk_q.sh[7:3] == i2c_link_pkg::MCODE_HI);
          trk_d.rd = ~sda & trk_q.sh[0];
          trk_d.wr = ~sda & ~trk_q.sh[0];
        end
      end else begin
        trk_d.cnt = trk_q.cnt + 4'h1;
        trk_d.sh = {trk_q.sh[6:0], sda};
      end
    end
    if (start_ev) begin
      trk_d.cnt = 4'h0;
      trk_d.first = 1'h1;
      trk_d.rd = 1'h0;
      trk_d.wr = 1'h0;
    end
    if (stop_ev) begin
      trk_d.first = 1'h0;
      trk_d.rd = 1'h0;
      trk_d.wr = 1'h0;
      trk_d.hs = 1'h0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      trk_q <= '{scl: 1'h1, sda: 1'h1, default: '0};
    end else begin
      trk_q <= trk_d;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence ack_low_s;
    !sda [*8];
  endsequence
  sequence bus_free_s;
    scl [*8];
  endsequence

  AST_SLAVE_SDA_HOLD: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave moved sda while scl high");
  AST_FREE_AFTER_STOP: assert property (stop_ev |=> bus_free_s)
    else $error("scl pulled low right after stop");
  AST_ACK_HELD: assert property (rise9 && !sda |-> ack_low_s)
    else $error("ack not held low through clock high");
  AST_ACK_ON_NINTH: assert property (rise && sda_s_oe && !trk_q.rd |-> trk_q.cnt == 4'h8)
    else $error("slave drove sda outside the ninth bit");
  AST_FOREIGN_NO_ACK: assert property (rise9 && trk_q.first
      && trk_q.sh[7:1] != {i2c_link_pkg::ADDR_HI, address_select_pin} |-> sda)
    else $error("foreign address acknowledged");
  AST_MCODE_NO_ACK: assert property (rise9 && trk_q.first
      && trk_q.sh[7:3] == i2c_link_pkg::MCODE_HI |-> !sda_s_oe [*4])
    else $error("master code acknowledged");
  AST_WRITE_ACK: assert property (rise9 && trk_q.wr |-> !sda)
    else $error("write byte not acknowledged");
  AST_NACK_RELEASE: assert property (rise9 && trk_q.rd && sda |-> !sda_s_oe [*8])
    else $error("slave kept sda after master nack");
  AST_NO_STRETCH_FS: assert property (!trk_q.hs |-> !scl_s_oe)
    else $error("scl stretched outside high speed");
  AST_STRETCH_ENDS: assert property ($rose(scl_s_oe) |-> ##[1:1000] !scl_s_oe)
    else $error("scl stretch did not end");
endmodule
`default_nettype wire
